/* File: hdl/switch_status_fault_readout.sv */
// Functional notes
// R1 - read-only switch status at address 0x1f, read bit 0; writes ignored
// R2 - status asked for in one frame is shifted out in the next frame
// R3 - each of 22 input bits reads 1 for closed, 0 for open switch
// R4 - response: 23 fault summary, 22 int flag, 21..14 prog, 13..0 ground
// R5 - status response upper byte echoes command byte 0011_1110
// R6 - fault summary is OR of all fault flags and wetting faults
// R7 - int flag sets on any switch change or fault onset
// R8 - after power-on reset both fault summary and int flag read 1
// R9 - int flag clears after any frame carrying it, even if cause persists
// R10 - fault summary stays until fault register read; read clears all flags; the wetting part follows the live input and drops without a read
// R11 - a cleared fault flag sets again at once while its condition persists
// R12 - persisting fault gives no new interrupt until it goes and recurs
// R13 - flags ride bits 23 and 22 of every command response
// R14 - master opens with chip select falling, then exactly 32 clocks
// R15 - interrupt output releases 1.0 ms after chip select falls
// R16 - fault flags return in the frame after the fault register read
// R17 - fault response reports faults, int flag, echo 0100_0010
// R18 - fault bit map 10..0; each bit clears on read once condition gone
// R19 - after low-power return first frame shows both flags and inputs
// R20 - frame: addr 31..25, rw bit 24, data 23..0, msb first
// R21 - interrupt output asserts when int flag sets, held until timed release
`timescale 1ns/1ps

module switch_status_fault_readout #(
  parameter int INT_RELEASE_CYCLES = switch_status_pkg::INT_RELEASE_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        spi_sck_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  output logic             int_n_o,
  input  wire logic [13:0] ground_switch_input_i,
  input  wire logic [7:0]  programmable_switch_input_i,
  input  wire logic        undervoltage_flag_i,
  input  wire logic        overvoltage_flag_i,
  input  wire logic        thermal_warning_flag_i,
  input  wire logic        overtemp_flag_i,
  input  wire logic        hash_mismatch_i,
  input  wire logic        wetting_fault_i,
  input  wire logic        int_pin_wake_i,
  input  wire logic        wake_pin_wake_i,
  input  wire logic        spi_wake_i,
  input  wire logic        lpm_exit_i
);

  // ==========================================================================
  // input synchronisers
  logic [2:0]                            link_s;
  logic [switch_status_pkg::NUM_SWITCH-1:0] sw_s;
  logic [switch_status_pkg::COND_W-1:0]  cond_s;
  logic                                  sck_s;
  logic                                  cs_n_s;
  logic                                  mosi_s;

  sync_2ff #(
    .W    (3),
    .INIT (3'h2)
  ) u_link_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({spi_sck_i, spi_cs_n_i, spi_mosi_i}),
    .sync_o  (link_s)
  );

  sync_2ff #(
    .W    (switch_status_pkg::NUM_SWITCH + switch_status_pkg::COND_W),
    .INIT ('0)
  ) u_field_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({lpm_exit_i, spi_wake_i, wake_pin_wake_i, int_pin_wake_i,
               wetting_fault_i, hash_mismatch_i, overtemp_flag_i,
               thermal_warning_flag_i, overvoltage_flag_i,
               undervoltage_flag_i,
               programmable_switch_input_i, ground_switch_input_i}),
    .sync_o  ({cond_s, sw_s})
  );

  assign sck_s  = link_s[2];
  assign cs_n_s = link_s[1];
  assign mosi_s = link_s[0];

  // ==========================================================================
  // edge detection on the sampled link
  logic sck_q_r;
  logic cs_n_q_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q_r  <= 1'b0;
      cs_n_q_r <= 1'b1;
    end else begin
      sck_q_r  <= sck_s;
      cs_n_q_r <= cs_n_s;
    end
  end

  assign sck_rise = sck_s & ~sck_q_r & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_q_r & ~cs_n_s;
  assign cs_fall  = ~cs_n_s & cs_n_q_r; // R14
  assign cs_rise  = cs_n_s & ~cs_n_q_r;

  // ==========================================================================
  // receive shifter and frame decode
  logic [switch_status_pkg::FRAME_BITS-1:0] rx_r;
  logic [switch_status_pkg::BIT_CNT_W-1:0]  bit_cnt_r;
  switch_status_pkg::frame_t                rx_frame;
  logic                                     frame_len_ok;
  logic                                     frame_addr_ok;
  logic                                     spi_err_evt;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_r      <= '0;
      bit_cnt_r <= '0;
    end else if (cs_fall) begin
      bit_cnt_r <= '0;
    end else if (sck_rise) begin
      rx_r <= {rx_r[switch_status_pkg::FRAME_BITS-2:0], mosi_s}; // R20
      // saturate so an overlong frame can never wrap back to 32
      if (bit_cnt_r != '1) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end
  end

  assign rx_frame      = switch_status_pkg::frame_t'(rx_r); // R20
  assign frame_len_ok  = (bit_cnt_r ==
    6'(switch_status_pkg::FRAME_BITS)); // R14
  assign frame_addr_ok = (rx_frame.addr <= switch_status_pkg::ADDR_LAST_VALID);
  assign spi_err_evt   = cs_rise & ~(frame_len_ok & frame_addr_ok); // R18

  // ==========================================================================
  // pending response, answered in the next frame
  switch_status_pkg::resp_kind_t resp_kind_r;
  logic [7:0]                    echo_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_kind_r <= switch_status_pkg::RESP_STATUS;
      echo_r      <= switch_status_pkg::RESET_ECHO;
    end else if (cs_rise) begin
      if (frame_len_ok && frame_addr_ok) begin
        echo_r <= {rx_frame.addr, rx_frame.rw}; // R5 R17
        if (rx_frame.addr == switch_status_pkg::ADDR_SWITCH_INPUT_STATE &&
            !rx_frame.rw) begin
          resp_kind_r <= switch_status_pkg::RESP_STATUS; // R1 R2
        end else if (rx_frame.addr ==
                     switch_status_pkg::ADDR_FAULT_FLAG_REPORT &&
                     !rx_frame.rw) begin
          resp_kind_r <= switch_status_pkg::RESP_FAULT; // R16
        end else begin
          resp_kind_r <= switch_status_pkg::RESP_ECHO; // R1
        end
      end else begin
        // a broken frame is answered with plain switch status
        resp_kind_r <= switch_status_pkg::RESP_STATUS;
        echo_r      <= switch_status_pkg::RESET_ECHO;
      end
    end
  end

  // ==========================================================================
  // fault flags
  logic [switch_status_pkg::FLT_W-1:0]  fault_r;
  logic [switch_status_pkg::FLT_W-1:0]  fault_set;
  logic [switch_status_pkg::COND_W-1:0] cond_q_r;
  logic                                 fault_read;
  logic                                 fault_sum;

  assign fault_read = cs_fall &&
    (resp_kind_r == switch_status_pkg::RESP_FAULT); // R10 R16

  always_comb begin
    fault_set = '0;
    fault_set[switch_status_pkg::FLT_SPI_ERR]    = spi_err_evt;
    fault_set[switch_status_pkg::FLT_HASH]       =
      cond_s[switch_status_pkg::COND_HASH];
    fault_set[switch_status_pkg::FLT_UNDERVOLT]  =
      cond_s[switch_status_pkg::COND_UNDERVOLT];
    fault_set[switch_status_pkg::FLT_OVERVOLT]   =
      cond_s[switch_status_pkg::COND_OVERVOLT];
    fault_set[switch_status_pkg::FLT_THERM_WARN] =
      cond_s[switch_status_pkg::COND_THERM];
    fault_set[switch_status_pkg::FLT_OVERTEMP]   =
      cond_s[switch_status_pkg::COND_OVERTEMP];
    fault_set[switch_status_pkg::FLT_INT_WAKE]   =
      cond_s[switch_status_pkg::COND_INT_WAKE];
    fault_set[switch_status_pkg::FLT_PIN_WAKE]   =
      cond_s[switch_status_pkg::COND_PIN_WAKE];
    fault_set[switch_status_pkg::FLT_SPI_WAKE]   =
      cond_s[switch_status_pkg::COND_SPI_WAKE];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_r <= switch_status_pkg::FAULT_RESET; // R8
    end else begin
      // a live condition wins over the read clear
      fault_r <= (fault_read ? '0 : fault_r) | fault_set; // R10 R11 R18
    end
  end

  assign fault_sum = (|fault_r) |
    cond_s[switch_status_pkg::COND_WETTING]; // R6

  // ==========================================================================
  // interrupt flag
  logic [switch_status_pkg::NUM_SWITCH-1:0] sw_q_r;
  logic                                     int_evt;
  logic                                     int_flag_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_q_r   <= '0;
      cond_q_r <= '0;
    end else begin
      sw_q_r   <= sw_s;
      cond_q_r <= cond_s;
    end
  end

  // onsets only, so a steady fault raises one interrupt
  assign int_evt = (|(sw_s ^ sw_q_r)) |
                   (|(cond_s & ~cond_q_r)) |
                   spi_err_evt; // R7 R12 R19

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_flag_r <= 1'b1; // R8
    end else if (int_evt) begin
      int_flag_r <= 1'b1; // R7
    end else if (cs_fall) begin
      // cleared once latched into the outgoing word
      int_flag_r <= 1'b0; // R9 R13
    end
  end

  // ==========================================================================
  // response word and transmit shifter
  switch_status_pkg::frame_t                resp_word;
  logic [switch_status_pkg::FRAME_BITS-1:0] tx_r;

  always_comb begin
    resp_word      = '0;
    resp_word.addr = echo_r[7:1];
    resp_word.rw   = echo_r[0];
    resp_word.data[switch_status_pkg::RESP_FAULT_SUM_BIT] = fault_sum; // R13
    resp_word.data[switch_status_pkg::RESP_INT_FLAG_BIT]  = int_flag_r;
    case (resp_kind_r)
      switch_status_pkg::RESP_STATUS: begin
        resp_word.data[switch_status_pkg::NUM_SWITCH-1:0] = sw_s; // R3 R4
      end
      switch_status_pkg::RESP_FAULT: begin
        resp_word.data[switch_status_pkg::FLT_W-1:0] = fault_r; // R17 R18
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_r       <= '0;
      spi_miso_o <= 1'b0;
    end else if (cs_fall) begin
      tx_r       <= resp_word; // R2
      spi_miso_o <= resp_word[switch_status_pkg::FRAME_BITS-1];
    end else if (sck_fall) begin
      tx_r       <= {tx_r[switch_status_pkg::FRAME_BITS-2:0], 1'b0};
      spi_miso_o <= tx_r[switch_status_pkg::FRAME_BITS-2]; // R20
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_miso_oe_o <= 1'b0;
    end else begin
      spi_miso_oe_o <= ~cs_n_s;
    end
  end

  // ==========================================================================
  // interrupt output and release timer
  logic [switch_status_pkg::INT_TIMER_W-1:0] int_tmr_r;
  logic                                      int_tmr_run_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_n_o       <= 1'b0; // R8 R21
      int_tmr_r     <= '0;
      int_tmr_run_r <= 1'b0;
    end else if (int_evt) begin
      // a new event re-asserts and drops any pending release
      int_n_o       <= 1'b0; // R21
      int_tmr_run_r <= 1'b0;
    end else if (cs_fall) begin
      int_tmr_r     <= '0; // R15
      int_tmr_run_r <= 1'b1;
    end else if (int_tmr_run_r) begin
      if (int_tmr_r == 18'(INT_RELEASE_CYCLES - 1)) begin
        int_n_o       <= 1'b1; // R15
        int_tmr_run_r <= 1'b0;
      end else begin
        int_tmr_r <= int_tmr_r + 18'h0_0001;
      end
    end
  end

endmodule : switch_status_fault_readout

/* File: hdl/switch_status_pkg.sv */
package switch_status_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_PS      = 5000;
  localparam int INT_RELEASE_NS     = 1_000_000;
  // longest wait, so the cycle count rounds down
  localparam int INT_RELEASE_CYCLES = (INT_RELEASE_NS * 1000) / CLK_PERIOD_PS;
  localparam int INT_TIMER_W        = 18;

  // ==========================================================================
  // frame layout
  localparam int FRAME_BITS  = 32;
  localparam int BIT_CNT_W   = 6;
  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 24;
  localparam int NUM_GROUND  = 14;
  localparam int NUM_PROG    = 8;
  localparam int NUM_SWITCH  = NUM_GROUND + NUM_PROG;

  // ==========================================================================
  // command addresses
  localparam logic [6:0] ADDR_SWITCH_INPUT_STATE = 7'h1f;
  localparam logic [6:0] ADDR_FAULT_FLAG_REPORT  = 7'h21;
  localparam logic [6:0] ADDR_LAST_VALID         = 7'h24;
  localparam logic [7:0] RESET_ECHO              = 8'h3e;

  // ==========================================================================
  // response bit positions
  localparam int RESP_FAULT_SUM_BIT = 23;
  localparam int RESP_INT_FLAG_BIT  = 22;

  // fault_flag_report bit positions
  localparam int FLT_W          = 11;
  localparam int FLT_SPI_ERR    = 10;
  localparam int FLT_HASH       = 9;
  localparam int FLT_UNUSED     = 8;
  localparam int FLT_UNDERVOLT  = 7;
  localparam int FLT_OVERVOLT   = 6;
  localparam int FLT_THERM_WARN = 5;
  localparam int FLT_OVERTEMP   = 4;
  localparam int FLT_INT_WAKE   = 3;
  localparam int FLT_PIN_WAKE   = 2;
  localparam int FLT_SPI_WAKE   = 1;
  localparam int FLT_POR        = 0;
  localparam logic [10:0] FAULT_RESET = 11'h001;

  // condition input positions (synchronised as one vector)
  localparam int COND_W         = 10;
  localparam int COND_UNDERVOLT = 0;
  localparam int COND_OVERVOLT  = 1;
  localparam int COND_THERM     = 2;
  localparam int COND_OVERTEMP  = 3;
  localparam int COND_HASH      = 4;
  localparam int COND_WETTING   = 5;
  localparam int COND_INT_WAKE  = 6;
  localparam int COND_PIN_WAKE  = 7;
  localparam int COND_SPI_WAKE  = 8;
  localparam int COND_LPM_EXIT  = 9;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [6:0]  addr;
    logic        rw;
    logic [23:0] data;
  } frame_t;

  typedef enum logic [1:0] {
    RESP_STATUS = 2'b00,
    RESP_FAULT  = 2'b01,
    RESP_ECHO   = 2'b10
  } resp_kind_t;

endpackage : switch_status_pkg

/* File: hdl/sync_2ff.sv */
`timescale 1ns/1ps

module sync_2ff #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= INIT;
      sync_o <= INIT;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : sync_2ff

/* File: verification/spi_host_model.sv */
`timescale 1ns/1ps

module spi_host_model (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  // clock stands still low outside frames
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // half an 80 ns link clock period
  task automatic half();
    repeat (8) @(posedge clk_i);
    #1;
  endtask : half

  task automatic xfer(input switch_status_pkg::frame_t cmd, input int nbits,
                      output logic [31:0] rsp);
    logic [31:0] word;
    word = cmd;
    rsp = '0;
    @(posedge clk_i);
    #1;
    cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = word[31-i];
      half();
      sck_o = 1'b1;
      rsp = {rsp[30:0], miso_i};
      half();
      sck_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1;
    // released line must not keep its last value
    mosi_o = ~mosi_o;
    half();
  endtask : xfer
endmodule : spi_host_model

/* File: verification/switch_status_fault_readout_assertions.sv */
`timescale 1ns/1ps

module switch_status_fault_readout_assertions #(
  parameter int INT_RELEASE_CYCLES = switch_status_pkg::INT_RELEASE_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        spi_sck_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_miso_o,
  input  wire logic        spi_miso_oe_o,
  input  wire logic        int_n_o,
  input  wire logic [13:0] ground_switch_input_i,
  input  wire logic [7:0]  programmable_switch_input_i,
  input  wire logic        undervoltage_flag_i,
  input  wire logic        overtemp_flag_i,
  input  wire logic        hash_mismatch_i,
  input  wire logic        lpm_exit_i
);
  // ==========================================================================
  // cycles since the last chip select fall at the pin
  logic [31:0] since_cs_r;
  logic        cs_d_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_d_r     <= 1'b1;
      since_cs_r <= '0;
    end else begin
      cs_d_r <= spi_cs_n_i;
      if (cs_d_r && !spi_cs_n_i)
        since_cs_r <= '0;
      else if (since_cs_r != '1)
        since_cs_r <= since_cs_r + 1;
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence frame_open_s;
    $fell(spi_cs_n_i);
  endsequence
  sequence frame_close_s;
    $rose(spi_cs_n_i);
  endsequence
  sequence switch_move_s;
    $changed(ground_switch_input_i) || $changed(programmable_switch_input_i);
  endsequence

  // sync and edge detect take a few cycles, hence the short window
  switch_int_a: assert property (switch_move_s |-> ##[1:8] !int_n_o)
    else $error("no interrupt after switch change");
  fault_int_a: assert property (($rose(overtemp_flag_i) ||
    $rose(hash_mismatch_i) || $rose(undervoltage_flag_i)) |-> ##[1:8] !int_n_o)
    else $error("no interrupt after fault onset");
  lpm_int_a: assert property ($rose(lpm_exit_i) |-> ##[1:8] !int_n_o)
    else $error("no interrupt after low-power return");
  int_hold_a: assert property ($fell(int_n_o) |-> !int_n_o [*8])
    else $error("interrupt released too early");
  release_time_a: assert property ($rose(int_n_o) |->
    since_cs_r >= INT_RELEASE_CYCLES && since_cs_r <= INT_RELEASE_CYCLES + 8)
    else $error("interrupt released at wrong time");
  oe_on_a: assert property (frame_open_s |-> ##[1:5] spi_miso_oe_o)
    else $error("miso not driven in frame");
  oe_off_a: assert property (frame_close_s |-> ##[1:5] !spi_miso_oe_o)
    else $error("miso still driven after frame");
  miso_hold_a: assert property (spi_sck_i && $past(spi_sck_i)
    |-> $stable(spi_miso_o))
    else $error("miso moved while clock high");
  first_bit_a: assert property (frame_open_s |-> ##6 !spi_miso_o)
    else $error("echo msb not zero");
endmodule : switch_status_fault_readout_assertions

bind switch_status_fault_readout switch_status_fault_readout_assertions #(
  .INT_RELEASE_CYCLES(INT_RELEASE_CYCLES)
) u_chk (
  .clk_i                       (clk_i),
  .rst_n_i                     (rst_n_i),
  .spi_sck_i                   (spi_sck_i),
  .spi_cs_n_i                  (spi_cs_n_i),
  .spi_miso_o                  (spi_miso_o),
  .spi_miso_oe_o               (spi_miso_oe_o),
  .int_n_o                     (int_n_o),
  .ground_switch_input_i       (ground_switch_input_i),
  .programmable_switch_input_i (programmable_switch_input_i),
  .undervoltage_flag_i         (undervoltage_flag_i),
  .overtemp_flag_i             (overtemp_flag_i),
  .hash_mismatch_i             (hash_mismatch_i),
  .lpm_exit_i                  (lpm_exit_i)
);

/* File: verification/switch_status_fault_readout_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); \
  end \
end

module switch_status_fault_readout_tb;
  localparam logic [6:0] ST  = switch_status_pkg::ADDR_SWITCH_INPUT_STATE;
  localparam logic [6:0] FLT = switch_status_pkg::ADDR_FAULT_FLAG_REPORT;
  logic        clk_i, rst_n_i, sck, cs_n, mosi, miso, miso_oe, int_n, lpm;
  logic [13:0] ground;
  logic [7:0]  prog;
  logic [5:0]  cond;
  logic [2:0]  wake;
  logic [31:0] rsp;
  int          num_errors = 0;
  int          check_count = 0;

  wire miso_w = miso_oe ? miso : ~miso;

  switch_status_fault_readout #(.INT_RELEASE_CYCLES(50)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
    .int_n_o(int_n), .ground_switch_input_i(ground),
    .programmable_switch_input_i(prog), .undervoltage_flag_i(cond[0]),
    .overvoltage_flag_i(cond[1]), .thermal_warning_flag_i(cond[2]),
    .overtemp_flag_i(cond[3]), .hash_mismatch_i(cond[4]),
    .wetting_fault_i(cond[5]), .int_pin_wake_i(wake[2]),
    .wake_pin_wake_i(wake[1]), .spi_wake_i(wake[0]), .lpm_exit_i(lpm));

  spi_host_model host (.clk_i(clk_i), .miso_i(miso_w), .sck_o(sck),
                       .cs_n_o(cs_n), .mosi_o(mosi));

  function automatic logic [31:0] st(logic f, logic i);
    return {8'h3e, f, i, prog, ground};
  endfunction : st
  function automatic logic [31:0] fw(logic [21:0] d);
    return {8'h42, 2'b10, d};
  endfunction : fw

  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic xf(logic [6:0] a, logic w = 1'b0, int n = 32);
    switch_status_pkg::frame_t c;
    c = '{addr: a, rw: w, data: 24'hff_ffff};
    host.xfer(c, n, rsp);
  endtask : xf

  task automatic wait_int_low();
    int k;
    // look just after each edge so the flop output has settled
    for (k = 0; k < 40 && int_n !== 1'b0; k++)
      tick(1);
    check_count++;
    if (k == 40) begin
      num_errors++;
      $display("wrong value at %0t: interrupt never asserted", $time);
      tally_and_finish();
    end
  endtask : wait_int_low

  task automatic por_flags();
    xf(FLT);
    `CHK(rsp, st(1'b1, 1'b1))
    xf(ST);
    `CHK(rsp, fw(22'h00_0001))
    xf(ST);
    `CHK(rsp, st(1'b0, 1'b0))
    `CHK(int_n, 1'b1)
  endtask : por_flags

  task automatic switch_change();
    ground[13] = ~ground[13];
    prog[0] = ~prog[0];
    wait_int_low();
    tick(80);
    `CHK(int_n, 1'b0)
    xf(ST);
    `CHK(rsp, st(1'b0, 1'b1))
    xf(ST);
    `CHK(rsp, st(1'b0, 1'b0))
    `CHK(int_n, 1'b1)
  endtask : switch_change

  task automatic fault_conditions();
    int pos[5] = '{7, 6, 5, 4, 9};
    for (int i = 0; i < 5; i++) begin
      cond[i] = 1'b1;
      wait_int_low();
      xf(FLT);
      `CHK(rsp, st(1'b1, 1'b1))
      xf(ST);
      `CHK(rsp, fw(22'h00_0001 << pos[i]))
      xf(FLT);
      `CHK(rsp, st(1'b1, 1'b0))
      cond[i] = 1'b0;
      tick(6);
      xf(ST);
      `CHK(rsp, fw(22'h00_0001 << pos[i]))
      xf(ST);
      `CHK(rsp, st(1'b0, 1'b0))
    end
  endtask : fault_conditions

  task automatic wetting_summary();
    cond[5] = 1'b1;
    tick(6);
    xf(ST);
    `CHK(rsp[31:23], {8'h3e, 1'b1})
    cond[5] = 1'b0;
    tick(6);
    xf(ST);
    xf(ST);
    `CHK(rsp, st(1'b0, 1'b0))
  endtask : wetting_summary

  task automatic refused_frames();
    for (int i = 0; i < 2; i++) begin
      if (i == 0)
        xf(ST, 1'b0, 31);
      else
        xf(switch_status_pkg::ADDR_LAST_VALID + 7'h01);
      xf(FLT);
      `CHK(rsp, st(1'b1, 1'b1))
      xf(ST);
      `CHK(rsp, fw(22'h00_0400))
      xf(ST);
      `CHK(rsp, st(1'b0, 1'b0))
    end
  endtask : refused_frames

  task automatic write_ignored();
    xf(ST, 1'b1);
    xf(ST);
    `CHK(rsp, {8'h3f, 24'h00_0000})
    xf(ST);
    `CHK(rsp, st(1'b0, 1'b0))
  endtask : write_ignored

  task automatic lpm_return();
    wake = 3'b111;
    lpm = 1'b1;
    wait_int_low();
    wake = 3'b000;
    lpm = 1'b0;
    xf(FLT);
    `CHK(rsp, st(1'b1, 1'b1))
    xf(ST);
    `CHK(rsp, fw(22'h00_000e))
    xf(ST);
    `CHK(rsp, st(1'b0, 1'b0))
  endtask : lpm_return

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    rst_n_i = 1'b0;
    ground = 14'h1c3a;
    prog = 8'ha5;
    cond = '0;
    wake = '0;
    lpm = 1'b0;
    repeat (10) @(posedge clk_i);
    #1;
    `CHK(int_n, 1'b0)
    rst_n_i = 1'b1;
    tick(10);
    por_flags();
    switch_change();
    fault_conditions();
    wetting_summary();
    refused_frames();
    write_ignored();
    lpm_return();
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    tally_and_finish();
  end
endmodule : switch_status_fault_readout_tb
